// [hdl/converter_fault_supervisor.sv]
// Fault supervision for a step-down power module: fault latches, hiccup
// retry, power-good, gate gating, address select and bus helpers.
// Assumes comparator flags come from the analog front end and the serial
// engine outside handles framing and hands bytes in for PEC.
`timescale 1ns/1ps
`include "converter_fault_supervisor_defines.svh"

// Functional notes
// - Over-voltage latches off, power-good low.
// - OV, UV and OC latches clear only on enable toggle.
// - Low side discharges between OV thresholds.
// - Startup OV armed after POR wait, until soft-start.
// - Under-voltage latches off, both drives low.
// - Over-current trips at 18.8 A code.
// - Over-current latches or retries after 9 ms.
// - Over-temperature stops drives, resumes with hysteresis.
// - Power-good low on any fault or rail loss.
// - One current sample feeds telemetry and trip.
// - Ultrasonic option keeps low side above 20 kHz.
// - Address is one of 32 from three ranges.
// - Alert line and packet error check provided.
// - Telemetry refreshed every 108 us.
// - Registers writable after 5.5 ms POR wait.
// - Writable bytes are readable back.
// - OPERATION bit 7 turns module on/off.
// - On/off config bits 3 and 2 gate control.
module converter_fault_supervisor #(
  parameter int unsigned POR_WAIT_CYCLES =
    (`POR_WAIT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS,
  parameter int unsigned HICCUP_CYCLES = `HICCUP_NS / `MCLK_PERIOD_NS,
  parameter int unsigned TELEM_CYCLES = `TELEM_PERIOD_NS / `MCLK_PERIOD_NS,
  parameter int unsigned US_CYCLES =
    `ULTRASONIC_PERIOD_NS / `MCLK_PERIOD_NS,
  parameter logic [11:0] OC_TRIP = `OC_TRIP_CODE
) (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire converter_fault_supervisor_pkg::comp_flags_s comp_flags_i,
  input wire logic [11:0] current_sense_i,
  input wire logic soft_start_done_i,
  input wire logic enable_pin_i,
  input wire logic [7:0] operation_i,
  input wire logic [7:0] on_off_config_i,
  input wire logic fault_response_select_bit_i,
  input wire logic pulse_frequency_mode_i,
  input wire logic ultrasonic_sel_i,
  input wire logic pwm_high_req_i,
  input wire logic pwm_low_req_i,
  input wire logic [4:0] config_pin_two_i,
  input wire logic clear_faults_i,
  input wire logic pec_clear_i,
  input wire logic pec_valid_i,
  input wire logic [7:0] pec_byte_i,
  output logic high_side_drive_o,
  output logic low_side_drive_o,
  output logic power_good_out_o,
  output logic alert_output_o,
  output logic over_voltage_fault_o,
  output logic under_voltage_fault_o,
  output logic over_current_fault_o,
  output logic over_temp_fault_o,
  output logic hiccup_active_o,
  output logic startup_ov_armed_o,
  output logic regs_ready_o,
  output logic [11:0] iout_telemetry_o,
  output logic [6:0] slave_addr_o,
  output logic [7:0] pec_o,
  output logic [7:0] operation_rb_o,
  output logic [7:0] on_off_config_rb_o
);

  localparam int unsigned US_PULSE_CYCLES =
    (`US_PULSE_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS;

  // Local aliases for the shared counter type and the run states.
  typedef converter_fault_supervisor_pkg::cnt_t cnt_t;
  localparam converter_fault_supervisor_pkg::run_state_e ST_OFF =
    converter_fault_supervisor_pkg::ST_OFF;
  localparam converter_fault_supervisor_pkg::run_state_e ST_RUN =
    converter_fault_supervisor_pkg::ST_RUN;
  localparam converter_fault_supervisor_pkg::run_state_e ST_HICCUP =
    converter_fault_supervisor_pkg::ST_HICCUP;

  converter_fault_supervisor_pkg::supervisor_s s;
  converter_fault_supervisor_pkg::supervisor_s n;

  logic cmd_ok;
  logic pin_ok;
  logic en_now;
  logic en_rise;
  logic ov_det;
  logic uv_det;
  logic oc_now;
  logic fault_s_any;
  logic fault_n_any;
  logic running;

  function automatic logic [7:0] crc8_step(input logic [7:0] crc,
                                           input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `PEC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc8_step

  always_comb begin
    n = s;
    // Two-stage synchroniser; only stage two is looked at.
    n.sync1 = comp_flags_i;
    n.sync2 = s.sync1;
    // The single current sample serves both trip and telemetry.
    n.cur = current_sense_i;
    n.op_rb = operation_i;
    n.cfg_rb = on_off_config_i;

    cmd_ok = !on_off_config_i[`CFG_OP_CTRL_BIT] ||
             operation_i[`OP_ON_BIT];
    pin_ok = !on_off_config_i[`CFG_PIN_CTRL_BIT] || enable_pin_i;
    en_now = cmd_ok && pin_ok && s.sync2.rails_ok;
    en_rise = en_now && !s.enabled;
    n.enabled = en_now;

    // Power-on wait shared by startup OV arming and register readiness.
    if (!s.sync2.rails_ok) begin
      n.arm_cnt = '0;
    end else if (s.arm_cnt != cnt_t'(POR_WAIT_CYCLES)) begin
      n.arm_cnt = s.arm_cnt + cnt_t'(1);
    end
    n.regs_ready = s.arm_cnt == cnt_t'(POR_WAIT_CYCLES);
    n.startup_armed = (s.arm_cnt == cnt_t'(POR_WAIT_CYCLES)) &&
                      !soft_start_done_i;

    ov_det = s.sync2.ov_rise ||
             (s.startup_armed && s.sync2.startup_ov);
    uv_det = s.sync2.uv && s.state == ST_RUN && soft_start_done_i;
    oc_now = s.cur >= OC_TRIP;

    // Clear on enable rise; a detection in the same cycle wins.
    if (en_rise) begin
      n.latch.ov = 1'b0;
      n.latch.uv = 1'b0;
      n.latch.oc = 1'b0;
    end
    if (ov_det) begin
      n.latch.ov = 1'b1;
    end
    if (uv_det) begin
      n.latch.uv = 1'b1;
    end
    if (oc_now && s.state == ST_RUN && !fault_response_select_bit_i) begin
      n.latch.oc = 1'b1;
    end
    if (s.sync2.ot_hot) begin
      n.latch.ot = 1'b1;
    end else if (s.sync2.ot_cool) begin
      n.latch.ot = 1'b0;
    end

    fault_s_any = s.latch.ov || s.latch.uv || s.latch.oc || s.latch.ot;
    fault_n_any = n.latch.ov || n.latch.uv || n.latch.oc || n.latch.ot;

    n.hic_cnt = '0;
    case (s.state)
      ST_OFF: begin
        if (en_now && !fault_n_any) begin
          n.state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (oc_now && fault_response_select_bit_i) begin
          n.state = ST_HICCUP;
        end else if (!en_now || fault_n_any) begin
          n.state = ST_OFF;
        end
      end
      ST_HICCUP: begin
        n.hic_cnt = s.hic_cnt + cnt_t'(1);
        if (s.hic_cnt == cnt_t'(HICCUP_CYCLES - 1)) begin
          n.state = ST_OFF;
        end
      end
      default: begin
        n.state = ST_OFF;
      end
    endcase

    // Low-side discharge follows the OV band while the OV latch holds.
    if (!s.latch.ov) begin
      n.discharge = 1'b0;
    end else if (s.sync2.ov_rise) begin
      n.discharge = 1'b1;
    end else if (s.sync2.ov_below_fall) begin
      n.discharge = 1'b0;
    end

    running = s.state == ST_RUN && !fault_s_any;

    // Ultrasonic keep-alive: force a short low-side pulse if none for 50 us.
    if (!(running && pulse_frequency_mode_i && ultrasonic_sel_i) ||
        pwm_low_req_i || s.us_pulse != 8'h00) begin
      n.us_cnt = '0;
    end else begin
      n.us_cnt = s.us_cnt + cnt_t'(1);
    end
    if (s.us_pulse != 8'h00) begin
      n.us_pulse = s.us_pulse - 8'h01;
    end else if (s.us_cnt == cnt_t'(US_CYCLES - 1)) begin
      n.us_pulse = 8'(US_PULSE_CYCLES);
    end

    n.high_drv = running && pwm_high_req_i;
    n.low_drv = (s.discharge && !s.latch.uv) ||
                (running && (pwm_low_req_i ||
                 s.us_pulse != 8'h00));
    n.pg = running && soft_start_done_i && s.sync2.rails_ok;

    if (s.tel_cnt == cnt_t'(TELEM_CYCLES - 1)) begin
      n.tel_cnt = '0;
      n.iout_tel = s.cur;
    end else begin
      n.tel_cnt = s.tel_cnt + cnt_t'(1);
    end

    // Sticky alert status; a new fault in the clear cycle survives.
    if (clear_faults_i) begin
      n.status = '0;
    end
    n.status = n.status | n.latch;
    n.alert = (n.status != '0);

    if (config_pin_two_i < 5'd8) begin
      n.addr = `ADDR_BASE_LOW + {4'h0, config_pin_two_i[2:0]};
    end else if (config_pin_two_i < 5'd16) begin
      n.addr = `ADDR_BASE_MID + {4'h0, config_pin_two_i[2:0]};
    end else begin
      n.addr = `ADDR_BASE_HIGH + {3'h0, config_pin_two_i[3:0]};
    end

    if (pec_clear_i) begin
      n.pec = 8'h00;
    end else if (pec_valid_i) begin
      n.pec = crc8_step(s.pec, pec_byte_i);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s <= '0;
      s.addr <= `ADDR_BASE_LOW;
      s.op_rb <= `OPERATION_RESET;
      s.cfg_rb <= `ON_OFF_CONFIG_RESET;
    end else begin
      s <= n;
    end
  end

  always_comb begin
    high_side_drive_o = s.high_drv;
    low_side_drive_o = s.low_drv;
    power_good_out_o = s.pg;
    alert_output_o = s.alert;
    over_voltage_fault_o = s.latch.ov;
    under_voltage_fault_o = s.latch.uv;
    over_current_fault_o = s.latch.oc;
    over_temp_fault_o = s.latch.ot;
    hiccup_active_o = s.state == ST_HICCUP;
    startup_ov_armed_o = s.startup_armed;
    regs_ready_o = s.regs_ready;
    iout_telemetry_o = s.iout_tel;
    slave_addr_o = s.addr;
    pec_o = s.pec;
    operation_rb_o = s.op_rb;
    on_off_config_rb_o = s.cfg_rb;
  end

  chk_ov_latch_pg: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    s.sync2.ov_rise |=> over_voltage_fault_o ##1 !power_good_out_o)
    else $error("over-voltage did not latch and drop power-good");

  chk_latch_holds: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s.latch.uv && !en_rise) |=> s.latch.uv)
    else $error("under-voltage latch cleared without enable rise");

  chk_ov_discharge: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s.latch.ov && s.sync2.ov_rise && !s.latch.uv) |=> ##1 low_side_drive_o)
    else $error("low side not discharging above over-voltage level");

  chk_arm_wait: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s.arm_cnt != cnt_t'(POR_WAIT_CYCLES)) |=> !startup_ov_armed_o)
    else $error("startup over-voltage armed before power-on wait");

  chk_uv_drives: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    s.latch.uv |=> (!high_side_drive_o && !low_side_drive_o))
    else $error("gate drive active during under-voltage latch");

  chk_oc_trip: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s.cur >= OC_TRIP && s.state == ST_RUN && !fault_response_select_bit_i)
    |=> over_current_fault_o)
    else $error("over-current not latched at trip code");

  chk_hiccup_end: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s.state == ST_HICCUP && s.hic_cnt == cnt_t'(HICCUP_CYCLES - 1))
    |=> s.state == ST_OFF)
    else $error("hiccup did not end at its count");

  chk_hiccup_stay: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (s.state == ST_HICCUP && s.hic_cnt != cnt_t'(HICCUP_CYCLES - 1))
    |=> s.state == ST_HICCUP)
    else $error("hiccup ended early");

  chk_ot_high: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    s.sync2.ot_hot |=> ##1 !high_side_drive_o)
    else $error("high side active while over temperature");

  chk_pg_fault: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    (fault_s_any || !s.sync2.rails_ok) |=> !power_good_out_o)
    else $error("power-good high during a fault");

  chk_regs_ready: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    regs_ready_o |-> $past(s.arm_cnt) == cnt_t'(POR_WAIT_CYCLES))
    else $error("registers ready before power-on wait");

  chk_addr_range: assert property (
    @(posedge mclk_i) disable iff (srst_i)
    slave_addr_o inside {[7'h40:7'h47], [7'h60:7'h67], [7'h70:7'h7f]})
    else $error("slave address outside permitted ranges");

endmodule : converter_fault_supervisor

// [hdl/converter_fault_supervisor_defines.svh]
// Constants for the converter fault supervisor: offsets, bit positions,
// reset values and timing figures in their own units.
// Assumes a single 200 MHz system clock.
`ifndef CONVERTER_FAULT_SUPERVISOR_DEFINES_SVH
`define CONVERTER_FAULT_SUPERVISOR_DEFINES_SVH

`define MCLK_PERIOD_NS 5
`define POR_WAIT_NS 5500000
`define HICCUP_NS 9000000
`define TELEM_PERIOD_NS 108000
`define ULTRASONIC_PERIOD_NS 50000
`define US_PULSE_NS 80

// Current code LSB is 10 mA, so 18.8 A is code 1880.
`define OC_TRIP_CODE 12'h758

`define OP_ON_BIT 7
`define CFG_OP_CTRL_BIT 3
`define CFG_PIN_CTRL_BIT 2
`define OPERATION_RESET 8'h80
`define ON_OFF_CONFIG_RESET 8'h1f

`define ADDR_BASE_LOW 7'h40
`define ADDR_BASE_MID 7'h60
`define ADDR_BASE_HIGH 7'h70
`define PEC_POLY 8'h07

`endif

// [hdl/converter_fault_supervisor_pkg.sv]
// Types shared by the converter fault supervisor.
// Assumes the constants header is compiled alongside.
package converter_fault_supervisor_pkg;

  typedef logic [23:0] cnt_t;
  typedef logic [11:0] cur_t;

  typedef struct packed {
    logic ov_rise;
    logic ov_below_fall;
    logic startup_ov;
    logic uv;
    logic ot_hot;
    logic ot_cool;
    logic rails_ok;
  } comp_flags_s;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_RUN,
    ST_HICCUP
  } run_state_e;

  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic ot;
  } fault_s;

  typedef struct packed {
    comp_flags_s sync1;
    comp_flags_s sync2;
    cur_t cur;
    cur_t iout_tel;
    logic enabled;
    cnt_t arm_cnt;
    logic startup_armed;
    logic regs_ready;
    fault_s latch;
    fault_s status;
    logic discharge;
    run_state_e state;
    cnt_t hic_cnt;
    cnt_t tel_cnt;
    cnt_t us_cnt;
    logic [7:0] us_pulse;
    logic high_drv;
    logic low_drv;
    logic pg;
    logic alert;
    logic [6:0] addr;
    logic [7:0] pec;
    logic [7:0] op_rb;
    logic [7:0] cfg_rb;
  } supervisor_s;

endpackage : converter_fault_supervisor_pkg

// [verification/stage_model.sv]
// Power stage and sense comparators seen from the supervisor.
// Assumes the bench sets the output level in percent of target and
// the inductor temperature in degrees.
`timescale 1ns/1ps
module stage_model #(
  parameter int BOOT_PCT = 110
) (
  input wire logic mclk_i,
  input wire logic [7:0] vout_pct_i,
  input wire logic [7:0] temp_c_i,
  input wire logic rails_ok_i,
  output converter_fault_supervisor_pkg::comp_flags_s flags_o
);
  // Comparators are registered so that flags move only after an edge.
  always_ff @(posedge mclk_i) begin
    flags_o.ov_rise <= vout_pct_i >= 8'h78;
    flags_o.ov_below_fall <= vout_pct_i < 8'h64;
    flags_o.startup_ov <= vout_pct_i > BOOT_PCT;
    flags_o.uv <= vout_pct_i < 8'h4a;
    flags_o.ot_hot <= temp_c_i >= 8'h88;
    flags_o.ot_cool <= temp_c_i <= 8'h7a;
    flags_o.rails_ok <= rails_ok_i;
  end
endmodule : stage_model

// [verification/tb.sv]
// Self-checking bench for the converter fault supervisor.
// Assumes shortened counts and the stage model for the comparators.
`timescale 1ns/1ps
module tb;
  localparam int POR = 20;
  localparam int HIC = 16;
  logic mclk_i, srst_i, soft_start_done_i, enable_pin_i, rails;
  logic fault_response_select_bit_i, pulse_frequency_mode_i;
  logic ultrasonic_sel_i, pwm_high_req_i, pwm_low_req_i;
  logic clear_faults_i, pec_clear_i, pec_valid_i;
  logic [11:0] current_sense_i, iout_telemetry_o;
  logic [7:0] operation_i, on_off_config_i, pec_byte_i, vout, temp;
  logic [7:0] pec_o, operation_rb_o, on_off_config_rb_o;
  logic [4:0] config_pin_two_i;
  logic [6:0] slave_addr_o;
  logic high_side_drive_o, low_side_drive_o, power_good_out_o;
  logic alert_output_o, over_voltage_fault_o, under_voltage_fault_o;
  logic over_current_fault_o, over_temp_fault_o, hiccup_active_o;
  logic startup_ov_armed_o, regs_ready_o;
  converter_fault_supervisor_pkg::comp_flags_s comp_flags_i;
  int bad_count, n_compared, cyc;
  wire [2:0] drv = {power_good_out_o, high_side_drive_o, low_side_drive_o};
  wire [3:0] flt = {over_voltage_fault_o, under_voltage_fault_o,
    over_current_fault_o, over_temp_fault_o};

  stage_model stage_model_i (.mclk_i, .vout_pct_i(vout), .temp_c_i(temp),
    .rails_ok_i(rails), .flags_o(comp_flags_i));
  converter_fault_supervisor #(.POR_WAIT_CYCLES(POR),
    .HICCUP_CYCLES(HIC), .TELEM_CYCLES(8), .US_CYCLES(12)
  ) converter_fault_supervisor_i (.mclk_i, .srst_i, .comp_flags_i,
    .current_sense_i, .soft_start_done_i, .enable_pin_i, .operation_i,
    .on_off_config_i, .fault_response_select_bit_i,
    .pulse_frequency_mode_i, .ultrasonic_sel_i, .pwm_high_req_i,
    .pwm_low_req_i, .config_pin_two_i, .clear_faults_i, .pec_clear_i,
    .pec_valid_i, .pec_byte_i, .high_side_drive_o, .low_side_drive_o,
    .power_good_out_o, .alert_output_o, .over_voltage_fault_o,
    .under_voltage_fault_o, .over_current_fault_o, .over_temp_fault_o,
    .hiccup_active_o, .startup_ov_armed_o, .regs_ready_o,
    .iout_telemetry_o, .slave_addr_o, .pec_o, .operation_rb_o,
    .on_off_config_rb_o);

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  task automatic chk(input string nm, input logic [11:0] e,
                     input logic [11:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic done(input string nm);
    $display("test %s done", nm);
  endtask : done

  task automatic tog_pin;
    enable_pin_i = 1'b0;
    step(4);
    enable_pin_i = 1'b1;
    step(6);
  endtask : tog_pin

  task automatic tog_op;
    operation_i = 8'h00;
    step(4);
    operation_i = 8'h80;
    step(6);
  endtask : tog_op

  task automatic pec_in(input logic [7:0] b, input logic c);
    pec_byte_i = b;
    pec_valid_i = 1'b1;
    pec_clear_i = c;
    step(1);
    pec_valid_i = 1'b0;
    pec_clear_i = 1'b0;
    step(1);
  endtask : pec_in

  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // Hang guard sized well above the whole sequence.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 4000) begin
      bad_count++;
      finish_test;
    end
  end

  initial begin
    {srst_i, enable_pin_i, pwm_high_req_i} = 3'h7;
    {soft_start_done_i, rails, fault_response_select_bit_i} = 3'h0;
    {pulse_frequency_mode_i, ultrasonic_sel_i, pwm_low_req_i} = 3'h0;
    {clear_faults_i, pec_clear_i, pec_valid_i} = 3'h0;
    {current_sense_i, pec_byte_i, config_pin_two_i} = '0;
    operation_i = 8'h80;
    on_off_config_i = 8'h1f;
    vout = 8'h64;
    temp = 8'h19;
    step(5);
    chk("addr", 12'h040, slave_addr_o);
    chk("op_rb", 12'h080, operation_rb_o);
    chk("cfg_rb", 12'h01f, on_off_config_rb_o);
    chk("drv", 3'h0, drv);
    srst_i = 1'b0;
    rails = 1'b1;
    done("reset");
    step(POR + 3);
    chk("ready", 1'b0, regs_ready_o);
    step(1);
    chk("ready", 1'b1, regs_ready_o);
    chk("armed", 1'b1, startup_ov_armed_o);
    vout = 8'h73;
    step(6);
    chk("faults", 4'h8, flt);
    vout = 8'h64;
    tog_pin;
    soft_start_done_i = 1'b1;
    step(6);
    chk("armed", 1'b0, startup_ov_armed_o);
    chk("drv", 3'h6, drv);
    done("power_on");
    vout = 8'h7d;
    step(6);
    chk("faults", 4'h8, flt);
    chk("drv", 3'h1, drv);
    chk("alert", 1'b1, alert_output_o);
    vout = 8'h5a;
    step(6);
    chk("drv", 3'h0, drv);
    vout = 8'h7d;
    step(6);
    chk("drv", 3'h1, drv);
    vout = 8'h64;
    step(6);
    chk("faults", 4'h8, flt);
    tog_pin;
    chk("faults", 4'h0, flt);
    chk("drv", 3'h6, drv);
    clear_faults_i = 1'b1;
    step(2);
    clear_faults_i = 1'b0;
    chk("alert", 1'b0, alert_output_o);
    done("over_voltage");
    vout = 8'h46;
    step(6);
    chk("faults", 4'h4, flt);
    chk("drv", 3'h0, drv);
    clear_faults_i = 1'b1;
    step(1);
    clear_faults_i = 1'b0;
    chk("alert", 1'b1, alert_output_o);
    vout = 8'h64;
    tog_op;
    chk("faults", 4'h0, flt);
    on_off_config_i = 8'h17;
    vout = 8'h46;
    step(6);
    vout = 8'h64;
    tog_op;
    chk("faults", 4'h4, flt);
    tog_pin;
    chk("faults", 4'h0, flt);
    on_off_config_i = 8'h1f;
    done("under_voltage");
    current_sense_i = 12'h757;
    step(12);
    chk("faults", 4'h0, flt);
    chk("telem", 12'h757, iout_telemetry_o);
    current_sense_i = 12'h758;
    step(6);
    chk("faults", 4'h2, flt);
    chk("drv", 3'h0, drv);
    current_sense_i = 12'h000;
    step(6);
    chk("faults", 4'h2, flt);
    tog_pin;
    chk("faults", 4'h0, flt);
    fault_response_select_bit_i = 1'b1;
    current_sense_i = 12'h758;
    step(4);
    current_sense_i = 12'h000;
    chk("hiccup", 1'b1, hiccup_active_o);
    step(HIC - 3);
    chk("hiccup", 1'b1, hiccup_active_o);
    step(1);
    chk("hiccup", 1'b0, hiccup_active_o);
    step(4);
    chk("drv", 3'h6, drv);
    done("over_current");
    temp = 8'h8c;
    step(6);
    chk("faults", 4'h1, flt);
    chk("drv", 3'h0, drv);
    temp = 8'h82;
    step(6);
    chk("faults", 4'h1, flt);
    temp = 8'h78;
    step(6);
    chk("faults", 4'h0, flt);
    chk("drv", 3'h6, drv);
    done("over_temp");
    pwm_high_req_i = 1'b0;
    pulse_frequency_mode_i = 1'b1;
    ultrasonic_sel_i = 1'b1;
    step(12);
    chk("drv", 3'h4, drv);
    step(1);
    chk("drv", 3'h5, drv);
    step(15);
    chk("drv", 3'h5, drv);
    step(1);
    chk("drv", 3'h4, drv);
    {pwm_high_req_i, pwm_low_req_i, ultrasonic_sel_i} = 3'h6;
    step(2);
    chk("drv", 3'h7, drv);
    pwm_low_req_i = 1'b0;
    step(30);
    chk("drv", 3'h6, drv);
    pulse_frequency_mode_i = 1'b0;
    done("ultrasonic");
    for (int n = 0; n < 32; n++) begin
      config_pin_two_i = 5'(n);
      step(2);
      chk("addr", n < 8 ? 12'h040 + 12'(n) : n < 16 ?
        12'h058 + 12'(n) : 12'h060 + 12'(n), slave_addr_o);
    end
    operation_i = 8'h8f;
    on_off_config_i = 8'h1b;
    step(2);
    chk("op_rb", 12'h08f, operation_rb_o);
    chk("cfg_rb", 12'h01b, on_off_config_rb_o);
    done("address_readback");
    pec_in(8'h55, 1'b1);
    chk("pec", 12'h000, pec_o);
    pec_in(8'h01, 1'b0);
    chk("pec", 12'h007, pec_o);
    // A read frame keeps one check across the repeated start, no clear.
    pec_in(8'h80, 1'b0);
    chk("pec", 12'h09c, pec_o);
    done("pec");
    finish_test;
  end
endmodule : tb
